// ---- hw/ssbd_datapath.sv ----
// Purpose: Execute short branch, one-bit shifts and the subtract family
// Assumes: Partner fetches operands, holds flags and writes results back
// Notes:   Result and flags appear one cycle after start, with done
`timescale 1ns/1ps
`default_nettype none
module ssbd_datapath
    import ssbd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 start,
    input  wire logic                 binary_mode,
    input  wire logic                 escape_seen,
    input  wire logic [7:0]           opcode,
    input  wire logic [7:0]           mode_byte,
    input  wire logic [31:0]          operand_dst,
    input  wire logic [31:0]          operand_src,
    input  wire logic [7:0]           displacement,
    input  wire logic [15:0]          pc_in,
    input  wire logic                 carry_borrow_flag_in,
    input  wire logic                 aux_carry_flag_in,
    input  wire logic                 signed_overflow_flag_in,
    input  wire logic                 negative_flag_in,
    input  wire logic                 zero_flag_in,
    output logic                      done,
    output logic                      illegal_r,
    output ssbd_pkg::ssbd_op_t        op_kind_r,
    output ssbd_pkg::ssbd_src_t       src_kind_r,
    output ssbd_pkg::ssbd_size_t      op_size_r,
    output logic [31:0]               result_r,
    output logic [15:0]               pc_next_r,
    output logic                      carry_borrow_flag_r,
    output logic                      aux_carry_flag_r,
    output logic                      signed_overflow_flag_r,
    output logic                      negative_flag_r,
    output logic                      zero_flag_r
);
    ssbd_op_t   dec_op;
    ssbd_src_t  dec_src;
    ssbd_size_t dec_size;
    logic       ext_ok;
    logic       legacy_ok;
    logic       sub_cin;
    logic [31:0] diff;
    logic        diff_borrow;
    logic        diff_half;
    logic        diff_ovf;

    logic        done_nxt;
    logic        illegal_nxt;
    ssbd_op_t    op_kind_nxt;
    ssbd_src_t   src_kind_nxt;
    ssbd_size_t  op_size_nxt;
    logic [31:0] result_nxt;
    logic [15:0] pc_next_nxt;
    logic        cy_nxt;
    logic        ac_nxt;
    logic        ov_nxt;
    logic        n_nxt;
    logic        z_nxt;
    logic        done_r;

    function automatic logic top_bit(input logic [31:0] v,
                                     input ssbd_size_t s);
        unique case (s)
            SSBD_SZ_BYTE: top_bit = v[7];
            SSBD_SZ_WORD: top_bit = v[15];
            default:      top_bit = v[31];
        endcase
    endfunction

    // Shifts exist only as byte and word forms
    function automatic ssbd_size_t shift_size(input logic [3:0] m,
                                              output logic ok);
        ok = (m == MOD_IMM_B) || (m == MOD_IMM_W);
        shift_size = (m == MOD_IMM_W) ? SSBD_SZ_WORD : SSBD_SZ_BYTE;
    endfunction

    // Decode
    always_comb begin
        logic sh_ok;
        sh_ok     = 1'b0;
        ext_ok    = binary_mode ? escape_seen : !escape_seen;
        legacy_ok = binary_mode ? !escape_seen : escape_seen;
        dec_op    = SSBD_OP_NONE;
        dec_src   = SSBD_SRC_NONE;
        dec_size  = SSBD_SZ_BYTE;
        if (opcode == OPC_BRANCH && !escape_seen) begin
            dec_op = SSBD_OP_BRANCH;
        end else if (ext_ok && (opcode == OPC_SLL || opcode == OPC_SRA
                                || opcode == OPC_SRL)) begin
            dec_size = shift_size(mode_byte[3:0], sh_ok);
            dec_src  = SSBD_SRC_REG;
            if (sh_ok) begin
                dec_op = (opcode == OPC_SLL) ? SSBD_OP_SLL :
                         (opcode == OPC_SRA) ? SSBD_OP_SRA : SSBD_OP_SRL;
            end
        end else if ((opcode == OPC_MINUS_WITH_BORROW_OP_IMM || opcode == OPC_MINUS_WITH_BORROW_OP_DIR8)
                     && !escape_seen) begin
            dec_op  = SSBD_OP_MINUS_WITH_BORROW_OP;
            dec_src = (opcode == OPC_MINUS_WITH_BORROW_OP_IMM) ? SSBD_SRC_IMM
                                               : SSBD_SRC_DIR8;
        end else if (legacy_ok && (opcode[7:1] == OPC_MINUS_WITH_BORROW_OP_IND
                                   || opcode[7:3] == OPC_MINUS_WITH_BORROW_OP_BANK)) begin
            dec_op  = SSBD_OP_MINUS_WITH_BORROW_OP;
            dec_src = (opcode[3]) ? SSBD_SRC_REG
                                  : SSBD_SRC_IND_WORD;
        end else if (ext_ok) begin
            unique case (opcode)
                OPC_SUB_BYTE, OPC_SUB_WORD, OPC_SUB_DWORD: begin
                    dec_op   = SSBD_OP_SUB;
                    dec_src  = SSBD_SRC_REG;
                    dec_size = (opcode == OPC_SUB_BYTE) ? SSBD_SZ_BYTE :
                               (opcode == OPC_SUB_WORD) ? SSBD_SZ_WORD
                                                        : SSBD_SZ_DWORD;
                end
                OPC_SUB_MIXED: begin
                    dec_op = SSBD_OP_SUB;
                    unique case (mode_byte[3:0])
                        MOD_IMM_B:   dec_src = SSBD_SRC_IMM;
                        MOD_DIR8_B:  dec_src = SSBD_SRC_DIR8;
                        MOD_DIR16_B: dec_src = SSBD_SRC_DIR16;
                        MOD_IND_W:   dec_src = SSBD_SRC_IND_WORD;
                        MOD_IND_D:   dec_src = SSBD_SRC_IND_DWORD;
                        MOD_IMM_W, MOD_DIR8_W, MOD_DIR16_W: begin
                            dec_size = SSBD_SZ_WORD;
                            dec_src  = (mode_byte[3:0] == MOD_IMM_W)
                                ? SSBD_SRC_IMM
                                : (mode_byte[3:0] == MOD_DIR8_W)
                                ? SSBD_SRC_DIR8 : SSBD_SRC_DIR16;
                        end
                        MOD_IMM_D: begin
                            dec_size = SSBD_SZ_DWORD;
                            dec_src  = SSBD_SRC_IMM;
                        end
                        default: dec_op = SSBD_OP_NONE;
                    endcase
                end
                default: dec_op = SSBD_OP_NONE;
            endcase
        end
    end

    // SUB ignores the incoming carry; borrow form is always a byte
    assign sub_cin = (dec_op == SSBD_OP_MINUS_WITH_BORROW_OP) && carry_borrow_flag_in;

    ssbd_subtractor u_sub (
        .minuend     (operand_dst),
        .subtrahend  (operand_src),
        .borrow_in   (sub_cin),
        .size        (dec_size),
        .difference  (diff),
        .borrow_out  (diff_borrow),
        .half_borrow (diff_half),
        .overflow    (diff_ovf)
    );

    // Execute
    always_comb begin
        done_nxt     = start;
        illegal_nxt  = illegal_r;
        op_kind_nxt  = op_kind_r;
        src_kind_nxt = src_kind_r;
        op_size_nxt  = op_size_r;
        result_nxt   = result_r;
        pc_next_nxt  = pc_next_r;
        cy_nxt       = carry_borrow_flag_r;
        ac_nxt       = aux_carry_flag_r;
        ov_nxt       = signed_overflow_flag_r;
        n_nxt        = negative_flag_r;
        z_nxt        = zero_flag_r;
        if (start) begin
            illegal_nxt  = (dec_op == SSBD_OP_NONE);
            op_kind_nxt  = dec_op;
            src_kind_nxt = dec_src;
            op_size_nxt  = dec_size;
            // Unused flags pass through so the partner may write all five
            cy_nxt       = carry_borrow_flag_in;
            ac_nxt       = aux_carry_flag_in;
            ov_nxt       = signed_overflow_flag_in;
            n_nxt        = negative_flag_in;
            z_nxt        = zero_flag_in;
            result_nxt   = operand_dst;
            pc_next_nxt  = pc_in + PC_STEP;
            unique case (dec_op)
                SSBD_OP_BRANCH: pc_next_nxt = pc_in + PC_STEP
                    + {{(16-DISP_W){displacement[7]}}, displacement};
                SSBD_OP_SLL: begin
                    result_nxt = {operand_dst[30:0], 1'b0};
                    cy_nxt     = top_bit(operand_dst, dec_size);
                end
                SSBD_OP_SRA: begin
                    result_nxt = {1'b0, operand_dst[31:1]};
                    if (dec_size == SSBD_SZ_WORD)
                        result_nxt[15] = operand_dst[15];
                    else
                        result_nxt[7] = operand_dst[7];
                    cy_nxt = operand_dst[0];
                end
                SSBD_OP_SRL: begin
                    result_nxt = {1'b0, operand_dst[31:1]};
                    if (dec_size == SSBD_SZ_WORD)
                        result_nxt[15] = 1'b0;
                    else
                        result_nxt[7] = 1'b0;
                    cy_nxt = operand_dst[0];
                end
                SSBD_OP_SUB, SSBD_OP_MINUS_WITH_BORROW_OP: begin
                    result_nxt = diff;
                    cy_nxt     = diff_borrow;
                    ov_nxt     = diff_ovf;
                    if (dec_size == SSBD_SZ_BYTE)
                        ac_nxt = diff_half;
                end
                default: ;
            endcase
            if (dec_op inside {SSBD_OP_SLL, SSBD_OP_SRA, SSBD_OP_SRL}) begin
                // Shift results are confined to their width
                result_nxt = (dec_size == SSBD_SZ_WORD)
                    ? {16'h0000, result_nxt[15:0]}
                    : {24'h00_0000, result_nxt[7:0]};
            end
            if (dec_op != SSBD_OP_BRANCH && dec_op != SSBD_OP_NONE) begin
                n_nxt = top_bit(result_nxt, dec_size);
                z_nxt = (result_nxt == 32'h0000_0000);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            done_r                 <= 1'b0;
            illegal_r              <= 1'b0;
            op_kind_r              <= SSBD_OP_NONE;
            src_kind_r             <= SSBD_SRC_NONE;
            op_size_r              <= SSBD_SZ_BYTE;
            result_r               <= 32'h0000_0000;
            pc_next_r              <= 16'h0000;
            carry_borrow_flag_r    <= 1'b0;
            aux_carry_flag_r       <= 1'b0;
            signed_overflow_flag_r <= 1'b0;
            negative_flag_r        <= 1'b0;
            zero_flag_r            <= 1'b0;
        end else begin
            done_r                 <= done_nxt;
            illegal_r              <= illegal_nxt;
            op_kind_r              <= op_kind_nxt;
            src_kind_r             <= src_kind_nxt;
            op_size_r              <= op_size_nxt;
            result_r               <= result_nxt;
            pc_next_r              <= pc_next_nxt;
            carry_borrow_flag_r    <= cy_nxt;
            aux_carry_flag_r       <= ac_nxt;
            signed_overflow_flag_r <= ov_nxt;
            negative_flag_r        <= n_nxt;
            zero_flag_r            <= z_nxt;
        end
    end

    assign done = done_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_branch;
        start && dec_op == SSBD_OP_BRANCH |=> pc_next_r == $past(pc_in)
            + PC_STEP + {{8{$past(displacement[7])}}, $past(displacement)};
    endproperty
    a_branch: assert property (p_branch) else $error("bad target");
    property p_branch_flags;
        start && dec_op == SSBD_OP_BRANCH |=> carry_borrow_flag_r
            == $past(carry_borrow_flag_in) && zero_flag_r == $past(zero_flag_in);
    endproperty
    a_branch_flags: assert property (p_branch_flags) else $error("flags");
    property p_sll;
        start && dec_op == SSBD_OP_SLL && dec_size == SSBD_SZ_BYTE |=>
            result_r[7:0] == {$past(operand_dst[6:0]), 1'b0}
            && carry_borrow_flag_r == $past(operand_dst[7]);
    endproperty
    a_sll: assert property (p_sll) else $error("left shift");
    property p_sra;
        start && dec_op == SSBD_OP_SRA && dec_size == SSBD_SZ_WORD |=>
            result_r[15] == $past(operand_dst[15])
            && carry_borrow_flag_r == $past(operand_dst[0]);
    endproperty
    a_sra: assert property (p_sra) else $error("arith shift");
    property p_srl;
        start && dec_op == SSBD_OP_SRL && dec_size == SSBD_SZ_BYTE |=>
            result_r[7:0] == {1'b0, $past(operand_dst[7:1])};
    endproperty
    a_srl: assert property (p_srl) else $error("logical shift");
    property p_sub_byte;
        start && dec_op == SSBD_OP_SUB && dec_size == SSBD_SZ_BYTE |=>
            carry_borrow_flag_r == ($past(operand_dst[7:0])
                                    < $past(operand_src[7:0]));
    endproperty
    a_sub_byte: assert property (p_sub_byte) else $error("borrow");
    property p_sub_word_ac;
        start && dec_op == SSBD_OP_SUB && dec_size != SSBD_SZ_BYTE |=>
            aux_carry_flag_r == $past(aux_carry_flag_in);
    endproperty
    a_sub_word_ac: assert property (p_sub_word_ac) else $error("ac");
    property p_ovf;
        start && dec_op == SSBD_OP_SUB && dec_size == SSBD_SZ_WORD |=>
            signed_overflow_flag_r == (($past(operand_dst[15])
            ^ $past(operand_src[15])) & ($past(operand_dst[15]) ^ result_r[15]));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow");
    property p_minus_with_borrow_op_ac;
        start && dec_op == SSBD_OP_MINUS_WITH_BORROW_OP |=> aux_carry_flag_r ==
            ({1'b0, $past(operand_dst[3:0])} < {1'b0, $past(operand_src[3:0])}
             + {4'h0, $past(carry_borrow_flag_in)});
    endproperty
    a_minus_with_borrow_op_ac: assert property (p_minus_with_borrow_op_ac) else $error("half borrow");
    property p_escape;
        start && binary_mode && !escape_seen && opcode == OPC_SUB_BYTE |=>
            op_kind_r == SSBD_OP_MINUS_WITH_BORROW_OP;
    endproperty
    a_escape: assert property (p_escape) else $error("escape map");
    property p_done;
        start |=> done ##1 (done == $past(start));
    endproperty
    a_done: assert property (p_done) else $error("done pulse");

    c_branch: cover property (start && dec_op == SSBD_OP_BRANCH);
    c_minus_with_borrow_op_borrow: cover property (start && dec_op == SSBD_OP_MINUS_WITH_BORROW_OP
                                   && carry_borrow_flag_in);
    c_sub_dword: cover property (start && dec_op == SSBD_OP_SUB
                                 && dec_size == SSBD_SZ_DWORD);
    c_illegal: cover property (start ##1 illegal_r);
endmodule
`default_nettype wire

// ---- hw/ssbd_pkg.sv ----
// Purpose: Shared types and encodings of the shift/subtract/branch datapath
// Assumes: Core decoder supplies operand values and opcode bytes
// Notes:   Opcode values are the first instruction byte after any escape
package ssbd_pkg;

    typedef enum logic [2:0] {
        SSBD_OP_NONE,
        SSBD_OP_BRANCH,
        SSBD_OP_SLL,
        SSBD_OP_SRA,
        SSBD_OP_SRL,
        SSBD_OP_SUB,
        SSBD_OP_MINUS_WITH_BORROW_OP
    } ssbd_op_t;

    typedef enum logic [1:0] {
        SSBD_SZ_BYTE,
        SSBD_SZ_WORD,
        SSBD_SZ_DWORD
    } ssbd_size_t;

    typedef enum logic [2:0] {
        SSBD_SRC_NONE,
        SSBD_SRC_REG,
        SSBD_SRC_IMM,
        SSBD_SRC_DIR8,
        SSBD_SRC_DIR16,
        SSBD_SRC_IND_WORD,
        SSBD_SRC_IND_DWORD,
        SSBD_SRC_ACC_FLAG
    } ssbd_src_t;

    localparam logic [7:0] OPC_BRANCH     = 8'h80;
    localparam logic [7:0] OPC_SLL        = 8'h3e;
    localparam logic [7:0] OPC_SRA        = 8'h0e;
    localparam logic [7:0] OPC_SRL        = 8'h1e;
    localparam logic [7:0] OPC_SUB_BYTE   = 8'h9c;
    localparam logic [7:0] OPC_SUB_WORD   = 8'h9d;
    localparam logic [7:0] OPC_SUB_MIXED  = 8'h9e;
    localparam logic [7:0] OPC_SUB_DWORD  = 8'h9f;
    localparam logic [7:0] OPC_MINUS_WITH_BORROW_OP_IMM   = 8'h94;
    localparam logic [7:0] OPC_MINUS_WITH_BORROW_OP_DIR8  = 8'h95;
    localparam logic [6:0] OPC_MINUS_WITH_BORROW_OP_IND   = 7'h4b;
    localparam logic [4:0] OPC_MINUS_WITH_BORROW_OP_BANK  = 5'h13;

    // Low nibble of the mode byte for the 0x9e and shift groups
    localparam logic [3:0] MOD_IMM_B   = 4'h0;
    localparam logic [3:0] MOD_DIR8_B  = 4'h1;
    localparam logic [3:0] MOD_DIR16_B = 4'h3;
    localparam logic [3:0] MOD_IMM_W   = 4'h4;
    localparam logic [3:0] MOD_DIR8_W  = 4'h5;
    localparam logic [3:0] MOD_DIR16_W = 4'h7;
    localparam logic [3:0] MOD_IMM_D   = 4'h8;
    localparam logic [3:0] MOD_IND_W   = 4'h9;
    localparam logic [3:0] MOD_IND_D   = 4'hb;

    localparam logic [15:0] PC_STEP    = 16'h0002;
    localparam int          DISP_W     = 8;
    localparam int          DATA_W     = 32;

endpackage

// ---- hw/ssbd_subtractor.sv ----
// Purpose: Width-selectable subtract with borrow, half borrow and overflow
// Assumes: Operands arrive in the low bits, upper bits are don't care
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module ssbd_subtractor
    import ssbd_pkg::*;
(
    input  wire logic [31:0]     minuend,
    input  wire logic [31:0]     subtrahend,
    input  wire logic            borrow_in,
    input  wire ssbd_pkg::ssbd_size_t size,
    output logic      [31:0]     difference,
    output logic                 borrow_out,
    output logic                 half_borrow,
    output logic                 overflow
);
    logic [31:0] mask;
    logic [32:0] wide;
    logic [4:0]  nib;
    logic        a_top;
    logic        b_top;
    logic        r_top;

    always_comb begin
        unique case (size)
            SSBD_SZ_BYTE: mask = 32'h0000_00ff;
            SSBD_SZ_WORD: mask = 32'h0000_ffff;
            default:      mask = 32'hffff_ffff;
        endcase
        // Masked operands make bit 32 the borrow out of any width's top
        wide = {1'b0, minuend & mask} - {1'b0, subtrahend & mask}
             - {32'h0000_0000, borrow_in};
        nib  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
             - {4'h0, borrow_in};
        difference  = wide[31:0] & mask;
        borrow_out  = wide[32];
        half_borrow = nib[4];
        unique case (size)
            SSBD_SZ_BYTE: begin
                a_top = minuend[7];
                b_top = subtrahend[7];
                r_top = wide[7];
            end
            SSBD_SZ_WORD: begin
                a_top = minuend[15];
                b_top = subtrahend[15];
                r_top = wide[15];
            end
            default: begin
                a_top = minuend[31];
                b_top = subtrahend[31];
                r_top = wide[31];
            end
        endcase
        // Signs differ and result sign left the minuend's
        overflow = (a_top ^ b_top) & (a_top ^ r_top);
    end
endmodule
`default_nettype wire

// ---- dv/ssbd_core_model.sv ----
// Purpose: Flag holder standing in for the core decoder and register file
// Assumes: New flags are written back on each done pulse; a load in the same cycle wins
// Notes:   Bench may preload flags to set carry-in and unaffected flags
`timescale 1ns/1ps
`default_nettype none
module ssbd_core_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       load,
    input  wire logic [4:0] load_flags,
    input  wire logic       done,
    input  wire logic [4:0] new_flags,
    output logic      [4:0] flags_r
);
    logic [4:0] flags_nxt;
    always_comb begin
        flags_nxt = flags_r;
        if (load) begin
            flags_nxt = load_flags;
        end else if (done) begin
            // Write-back keeps the borrow chain for multi-precision work
            flags_nxt = new_flags;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_r <= 5'h00;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the shift/subtract/branch datapath
// Assumes: Flags packed as carry, aux, overflow, negative, zero
// Notes:   Each operation is one start pulse, checked in the done cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssbd_pkg::*;
    logic clk, reset, start, bm, esc, load, done, ill;
    logic [7:0] opc, mb, disp;
    logic [31:0] dst, src, res;
    logic [15:0] pc, pcn;
    logic [4:0] lf;
    wire logic [4:0] fi, fo;
    ssbd_op_t op;
    ssbd_src_t sk;
    ssbd_size_t sz;
    int n_errors, checks, cycles;
    ssbd_datapath dut (.clk(clk), .reset(reset), .start(start),
        .binary_mode(bm), .escape_seen(esc), .opcode(opc), .mode_byte(mb),
        .operand_dst(dst), .operand_src(src), .displacement(disp),
        .pc_in(pc), .carry_borrow_flag_in(fi[4]), .aux_carry_flag_in(fi[3]),
        .signed_overflow_flag_in(fi[2]), .negative_flag_in(fi[1]),
        .zero_flag_in(fi[0]), .done(done), .illegal_r(ill), .op_kind_r(op),
        .src_kind_r(sk), .op_size_r(sz), .result_r(res), .pc_next_r(pcn),
        .carry_borrow_flag_r(fo[4]), .aux_carry_flag_r(fo[3]),
        .signed_overflow_flag_r(fo[2]), .negative_flag_r(fo[1]),
        .zero_flag_r(fo[0]));
    ssbd_core_model core (.clk(clk), .reset(reset), .load(load),
        .load_flags(lf), .done(done), .new_flags(fo), .flags_r(fi));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    // Preload flags, then one start; outputs sampled once done has landed
    task automatic go(input logic b, input logic e, input logic [7:0] o,
                      input logic [7:0] m, input logic [31:0] d,
                      input logic [31:0] s, input logic [4:0] f);
        @(posedge clk);
        load <= 1'b1;
        lf <= f;
        @(posedge clk);
        load <= 1'b0;
        start <= 1'b1;
        bm <= b;
        esc <= e;
        opc <= o;
        mb <= m;
        dst <= d;
        src <= s;
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk({31'h0, done}, 32'h1);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        {reset, start, bm, esc, load} = 5'b10000;
        {opc, mb, disp, lf} = '0;
        {dst, src} = '0;
        pc = 16'h0100;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({31'h0, done}, 32'h0);
        chk(res, 32'h0);
        disp <= 8'h21;
        go(1'b0, 1'b0, 8'h80, 8'h00, 32'h0, 32'h0, 5'h1f);
        chk({16'h0, pcn}, 32'h0123);
        chk({27'h0, fo}, 32'h1f);
        chk({29'h0, op}, {29'h0, SSBD_OP_BRANCH});
        disp <= 8'h80;
        go(1'b0, 1'b0, 8'h80, 8'h00, 32'h0, 32'h0, 5'h00);
        chk({16'h0, pcn}, 32'h0082);
        disp <= 8'h7f;
        go(1'b0, 1'b0, 8'h80, 8'h00, 32'h0, 32'h0, 5'h00);
        chk({16'h0, pcn}, 32'h0181);
        go(1'b1, 1'b1, 8'h3e, 8'h00, 32'hc5, 32'h0, 5'h00);
        chk(res, 32'h8a);
        chk({27'h0, fo}, 32'h12);
        chk({16'h0, pcn}, 32'h0102);
        go(1'b1, 1'b1, 8'h0e, 8'h00, 32'hc5, 32'h0, 5'h00);
        chk(res, 32'he2);
        chk({27'h0, fo}, 32'h12);
        go(1'b1, 1'b1, 8'h0e, 8'h04, 32'h8001, 32'h0, 5'h00);
        chk(res, 32'hc000);
        chk({27'h0, fo}, 32'h12);
        chk({30'h0, sz}, {30'h0, SSBD_SZ_WORD});
        go(1'b1, 1'b1, 8'h3e, 8'h04, 32'h8001, 32'h0, 5'h00);
        chk(res, 32'h0002);
        chk({27'h0, fo}, 32'h10);
        go(1'b1, 1'b1, 8'h1e, 8'h00, 32'hc5, 32'h0, 5'h00);
        chk(res, 32'h62);
        chk({27'h0, fo}, 32'h10);
        go(1'b1, 1'b1, 8'h1e, 8'h04, 32'h8001, 32'h0, 5'h0c);
        chk(res, 32'h4000);
        chk({27'h0, fo}, 32'h1c);
        go(1'b0, 1'b0, 8'h9c, 8'h10, 32'hc9, 32'h54, 5'h00);
        chk(res, 32'h75);
        chk({27'h0, fo}, 32'h04);
        chk({29'h0, op}, {29'h0, SSBD_OP_SUB});
        chk({31'h0, ill}, 32'h0);
        go(1'b0, 1'b0, 8'h9d, 8'h01, 32'h0, 32'h1, 5'h08);
        chk(res, 32'h0000ffff);
        chk({27'h0, fo}, 32'h1a);
        chk({30'h0, sz}, {30'h0, SSBD_SZ_WORD});
        go(1'b0, 1'b0, 8'h9f, 8'h01, 32'h80000000, 32'h1, 5'h00);
        chk(res, 32'h7fffffff);
        chk({27'h0, fo}, 32'h04);
        go(1'b0, 1'b0, 8'h9e, 8'h01, 32'h10, 32'h10, 5'h00);
        chk({27'h0, fo}, 32'h01);
        chk({29'h0, sk}, {29'h0, SSBD_SRC_DIR8});
        go(1'b0, 1'b0, 8'h9e, 8'h0b, 32'h0, 32'h1, 5'h00);
        chk(res, 32'hff);
        chk({27'h0, fo}, 32'h1a);
        chk({29'h0, sk}, {29'h0, SSBD_SRC_IND_DWORD});
        go(1'b0, 1'b0, 8'h94, 8'h54, 32'hc9, 32'h54, 5'h10);
        chk(res, 32'h74);
        chk({27'h0, fo}, 32'h04);
        go(1'b0, 1'b0, 8'h95, 8'h00, 32'h10, 32'h01, 5'h00);
        chk(res, 32'h0f);
        chk({27'h0, fo}, 32'h08);
        go(1'b0, 1'b1, 8'h96, 8'h00, 32'h80, 32'h01, 5'h00);
        chk(res, 32'h7f);
        chk({27'h0, fo}, 32'h0c);
        go(1'b1, 1'b1, 8'h3e, 8'h01, 32'h5a, 32'h0, 5'h00);
        chk({31'h0, ill}, 32'h1);
        chk(res, 32'h5a);
        // Mid-run reset must clear the registered ill, res and pcn outputs
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({31'h0, ill}, 32'h0);
        chk(res, 32'h0);
        chk({16'h0, pcn}, 32'h0);
        go(1'b1, 1'b0, 8'h9c, 8'h00, 32'h20, 32'h01, 5'h00);
        chk({29'h0, op}, {29'h0, SSBD_OP_MINUS_WITH_BORROW_OP});
        go(1'b1, 1'b1, 8'h9c, 8'h10, 32'h20, 32'h01, 5'h00);
        chk({29'h0, op}, {29'h0, SSBD_OP_SUB});
        conclude();
    end
endmodule
`default_nettype wire
